/* stp_loader_model.sv */
// Default loader model: SMBus, I2C or EEPROM word writes.
// Assumes ld_ack answers one cycle after each request.
`timescale 1ns/10ps
module stp_loader_model
  import stp_pkg::*;
(
  input wire logic core_clk,
  input wire logic ld_ack,
  output logic ld_req,
  output logic [1:0] ld_src,
  output logic [PORT_W-1:0] ld_port,
  output logic [7:0] ld_addr,
  output logic [31:0] ld_wdata
);
  // ************************************************************
  // One full-word write, even to read-only fields
  // ************************************************************
  initial
  begin
    ld_req = 1'b0;
    ld_src = SRC_SMBUS;
    ld_port = 3'h0;
    ld_addr = 8'h00;
    ld_wdata = 32'h0000_0000;
  end

  task automatic load(input logic [1:0] s, input logic [PORT_W-1:0] p, input logic [7:0] a,
      input logic [31:0] d, output bit ok);
    @(posedge core_clk);
    #1;
    ld_req = 1'b1;
    ld_src = s;
    ld_port = p;
    ld_addr = a;
    ld_wdata = d;
    @(posedge core_clk);
    #1;
    ok = (ld_ack === 1'b1);
    ld_req = 1'b0;
    ld_wdata = ~d;
  endtask
endmodule

/* stp_pkg.sv */
// Constants of the per-port tuning register bank of the switch.
// Assumes port 0 is the upstream port and the others are downstream.
package stp_pkg;

  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 3;
  localparam logic [PORT_W-1:0] UP_PORT = 3'h0;

  // ************************************************************
  // Byte offsets and word indices
  // ************************************************************
  localparam logic [7:0] OFS_WORD_C = 8'h80;
  localparam logic [7:0] OFS_WORD_D = 8'h84;
  localparam logic [7:0] OFS_WORD_E = 8'h88;
  localparam logic [7:0] OFS_TL = 8'h8C;
  localparam logic [1:0] IDX_WORD_C = 2'h0;
  localparam logic [1:0] IDX_WORD_D = 2'h1;
  localparam logic [1:0] IDX_WORD_E = 2'h2;
  localparam logic [1:0] IDX_TL = 2'h3;
  localparam int IDX_LSB = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RST_WORD_C = 32'h000F_0000;
  localparam logic [31:0] RST_WORD_D = 32'h0000_0000;
  localparam logic [31:0] RST_WORD_E_UP = 32'h7308_3333;
  localparam logic [31:0] RST_WORD_E_DN = 32'h3308_3333;
  localparam logic [31:0] RST_TL = 32'h0079_1894;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int KEEP_CFG_BIT = 11;
  localparam int RATE_CTRL_BIT = 30;
  localparam int GEN1_LIMIT_BIT = 31;
  localparam int RO_DISABLE_BIT = 6;
  localparam int ATTEMPT_LSB = 8;
  localparam int PORT_DISABLE_BIT = 10;
  localparam int PHY_RETRAIN_BIT = 16;

  // ************************************************************
  // Write masks: configuration side, loader side, global fields
  // ************************************************************
  localparam logic [31:0] CFG_MASK_C = 32'hFFFF_FFFF;
  localparam logic [31:0] CFG_MASK_D = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK_E = 32'hC000_0000;
  localparam logic [31:0] CFG_MASK_TL = 32'h0000_0060;
  localparam logic [31:0] LD_MASK_C = 32'hFFFF_FFFF;
  localparam logic [31:0] LD_MASK_D = 32'hFFFF_FFFF;
  localparam logic [31:0] LD_MASK_E = 32'hFFFF_FFFF;
  localparam logic [31:0] LD_MASK_TL = 32'hBFFF_1FFF;
  localparam logic [31:0] EEPROM_ONLY_TL = 32'h0000_0040;
  localparam logic [31:0] GLOBAL_MASK_E = 32'h3FFF_FFFF;
  localparam logic [31:0] GLOBAL_MASK_TL = 32'h3C00_10EF;

  // ************************************************************
  // Loader source codes
  // ************************************************************
  localparam logic [1:0] SRC_SMBUS = 2'h0;
  localparam logic [1:0] SRC_I2C = 2'h1;
  localparam logic [1:0] SRC_EEPROM = 2'h2;

endpackage

/* stp_port_if.sv */
// Write path and register contents between the bank and one port slice.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
interface stp_port_if;
  logic we;
  logic [1:0] widx;
  logic [31:0] wdata;
  logic [31:0] wmask;
  logic [31:0] word_c;
  logic [31:0] word_d;
  logic [31:0] word_e;
  logic [31:0] word_tl;

  modport bank (output we, output widx, output wdata, output wmask,
    input word_c, input word_d, input word_e, input word_tl);
  modport port (input we, input widx, input wdata, input wmask,
    output word_c, output word_d, output word_e, output word_tl);
endinterface

/* stp_port_regs.sv */
// Register slice of one switch port: four words with masked writes.
// Assumes the bank has already applied access and byte masks.
`timescale 1ns/10ps
module stp_port_regs
  import stp_pkg::*;
#(
  parameter bit IS_UP = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  stp_port_if.port pif
);

  typedef struct packed {
    logic [31:0] c;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] tl;
  } stp_slice_type;

  stp_slice_type st_q;
  stp_slice_type st_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction

  always_comb
  begin
    st_d = st_q;
    if (pif.we)
    begin
      unique case (pif.widx)
        IDX_WORD_C: st_d.c = merge(st_q.c, pif.wdata, pif.wmask);
        IDX_WORD_D: st_d.d = merge(st_q.d, pif.wdata, pif.wmask);
        IDX_WORD_E: st_d.e = merge(st_q.e, pif.wdata, pif.wmask);
        IDX_TL: st_d.tl = merge(st_q.tl, pif.wdata, pif.wmask);
      endcase
    end
  end

  // Upstream slice defaults rate change control to one
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q.c <= RST_WORD_C;
      st_q.d <= RST_WORD_D;
      st_q.e <= IS_UP ? RST_WORD_E_UP : RST_WORD_E_DN; // R4
      st_q.tl <= RST_TL; // R5
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pif.word_c = st_q.c;
  assign pif.word_d = st_q.d;
  assign pif.word_e = st_q.e;
  assign pif.word_tl = st_q.tl;

endmodule

/* stp_tuning_bank.sv */
// Tuning register bank for all ports of the switch, with config and loader ports.
// Assumes requests are one-cycle pulses on core_clk from same-domain logic.
`timescale 1ns/10ps

// What this block does
// R1: Loader writes defaults, even read-only fields
// R2: Global fields come from upstream copy only
// R3: Upstream link down clears config unless kept
// R4: Rate change control resets up 1, down 0
// R5: Rate change attempt count, reset 00b
// R6: Port disable bit turns port off
// R7: Ordering rule disable, loadable only from EEPROM
// R8: Phy error retrain disable, bit 0 of byte
// R9: Gen1 limit bit restricts port to 2.5 GT/s
module stp_tuning_bank
  import stp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [PORT_W-1:0] cfg_port,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic ld_req,
  input wire logic [1:0] ld_src,
  input wire logic [PORT_W-1:0] ld_port,
  input wire logic [7:0] ld_addr,
  input wire logic [31:0] ld_wdata,
  output logic ld_ack,
  input wire logic up_link_down,
  output logic cfg_clear,
  output logic keep_cfg_on_link_down,
  output logic ordering_rule_disable,
  output logic [NUM_PORTS-1:0] port_disable,
  output logic [NUM_PORTS-1:0] rate_change_control,
  output logic [NUM_PORTS-1:0] first_generation_speed_limit,
  output logic [2*NUM_PORTS-1:0] rate_change_attempt_count,
  output logic [NUM_PORTS-1:0] phy_retrain_disable,
  output logic [31:0] link_tuning_word_c,
  output logic [31:0] link_tuning_word_d
);

  typedef struct packed {
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic ld_ack;
    logic link_down_prev;
    logic cfg_clear;
  } stp_bank_type;

  stp_bank_type st_q;
  stp_bank_type st_d;

  logic [31:0] word_c_a [NUM_PORTS];
  logic [31:0] word_d_a [NUM_PORTS];
  logic [31:0] word_e_a [NUM_PORTS];
  logic [31:0] word_tl_a [NUM_PORTS];
  logic [31:0] view_e_a [NUM_PORTS];
  logic [31:0] view_tl_a [NUM_PORTS];
  logic [31:0] up_word_e;
  logic [31:0] up_word_tl;

  logic cfg_hit;
  logic ld_hit;
  logic [31:0] cfg_mask;
  logic [31:0] ld_mask;
  logic [31:0] be_lanes;
  logic link_down_rise;

  // ************************************************************
  // Access masks
  // ************************************************************
  function automatic logic mapped(input logic [7:0] addr);
    mapped = addr inside {OFS_WORD_C, OFS_WORD_D, OFS_WORD_E, OFS_TL};
  endfunction

  function automatic logic [31:0] cfg_word_mask(input logic [1:0] idx);
    logic [31:0] m;
    m = CFG_MASK_C;
    unique case (idx)
      IDX_WORD_C: m = CFG_MASK_C;
      IDX_WORD_D: m = CFG_MASK_D;
      IDX_WORD_E: m = CFG_MASK_E; // R9
      IDX_TL: m = CFG_MASK_TL;
    endcase
    cfg_word_mask = m;
  endfunction

  function automatic logic [31:0] ld_word_mask(input logic [1:0] idx, input logic eeprom);
    logic [31:0] m;
    m = LD_MASK_C;
    unique case (idx)
      IDX_WORD_C: m = LD_MASK_C;
      IDX_WORD_D: m = LD_MASK_D;
      IDX_WORD_E: m = LD_MASK_E; // R1
      IDX_TL: m = eeprom ? LD_MASK_TL : (LD_MASK_TL & ~EEPROM_ONLY_TL); // R7
    endcase
    ld_word_mask = m;
  endfunction

  // ************************************************************
  // Request decode
  // ************************************************************
  assign cfg_hit = cfg_req && cfg_we && mapped(cfg_addr) &&
                   (cfg_port < PORT_W'(NUM_PORTS));
  assign ld_hit = ld_req && mapped(ld_addr) && (ld_port < PORT_W'(NUM_PORTS));
  assign be_lanes = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign cfg_mask = cfg_word_mask(cfg_addr[IDX_LSB +: 2]) & be_lanes;
  assign ld_mask = ld_word_mask(ld_addr[IDX_LSB +: 2], ld_src == SRC_EEPROM);
  // Upstream link going down, same clock domain as the bank
  assign link_down_rise = up_link_down && !st_q.link_down_prev;

  // ************************************************************
  // Upstream copies of the global fields
  // ************************************************************
  assign up_word_e = word_e_a[UP_PORT]; // R2
  assign up_word_tl = word_tl_a[UP_PORT]; // R2

  // ************************************************************
  // Port slices
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_port
      stp_port_if pif ();
      logic ld_sel;
      logic cfg_sel;

      // Loader wins over a same-cycle configuration write
      assign ld_sel = ld_hit && (ld_port == PORT_W'(gi)); // R1
      assign cfg_sel = cfg_hit && (cfg_port == PORT_W'(gi));
      assign pif.we = ld_sel || cfg_sel;
      assign pif.widx = ld_sel ? ld_addr[IDX_LSB +: 2] : cfg_addr[IDX_LSB +: 2];
      assign pif.wdata = ld_sel ? ld_wdata : cfg_wdata;
      assign pif.wmask = ld_sel ? ld_mask : cfg_mask;

      stp_port_regs #(
        .IS_UP(PORT_W'(gi) == UP_PORT)
      ) u_regs (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pif(pif)
      );

      assign word_c_a[gi] = pif.word_c;
      assign word_d_a[gi] = pif.word_d;
      assign word_e_a[gi] = pif.word_e;
      assign word_tl_a[gi] = pif.word_tl;

      // Global fields always come from the upstream copy
      assign view_e_a[gi] = (pif.word_e & ~GLOBAL_MASK_E) |
                            (up_word_e & GLOBAL_MASK_E); // R2
      assign view_tl_a[gi] = (pif.word_tl & ~GLOBAL_MASK_TL) |
                             (up_word_tl & GLOBAL_MASK_TL); // R2

      assign port_disable[gi] = pif.word_tl[PORT_DISABLE_BIT]; // R6
      assign rate_change_control[gi] = pif.word_e[RATE_CTRL_BIT]; // R4
      assign first_generation_speed_limit[gi] = pif.word_e[GEN1_LIMIT_BIT]; // R9
      assign rate_change_attempt_count[2*gi +: 2] = pif.word_tl[ATTEMPT_LSB +: 2]; // R5
      assign phy_retrain_disable[gi] = pif.word_tl[PHY_RETRAIN_BIT]; // R8
    end
  endgenerate

  // ************************************************************
  // Read view and link-down handling
  // ************************************************************
  function automatic logic [31:0] read_word(input logic [PORT_W-1:0] p,
                                            input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (mapped(addr) && (p < PORT_W'(NUM_PORTS)))
    begin
      unique case (addr[IDX_LSB +: 2])
        IDX_WORD_C: v = word_c_a[p];
        IDX_WORD_D: v = word_d_a[UP_PORT]; // R2
        IDX_WORD_E: v = view_e_a[p]; // R2
        IDX_TL: v = view_tl_a[p]; // R2
      endcase
    end
    read_word = v;
  endfunction

  always_comb
  begin
    st_d = st_q;
    st_d.cfg_ack = cfg_req;
    st_d.ld_ack = ld_req;
    if (cfg_req && !cfg_we)
    begin
      st_d.cfg_rdata = read_word(cfg_port, cfg_addr);
    end
    st_d.link_down_prev = up_link_down;
    st_d.cfg_clear = link_down_rise && !up_word_e[KEEP_CFG_BIT]; // R3
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Top outputs
  // ************************************************************
  assign cfg_ack = st_q.cfg_ack;
  assign cfg_rdata = st_q.cfg_rdata;
  assign ld_ack = st_q.ld_ack;
  assign cfg_clear = st_q.cfg_clear;
  assign keep_cfg_on_link_down = up_word_e[KEEP_CFG_BIT]; // R3
  assign ordering_rule_disable = up_word_tl[RO_DISABLE_BIT]; // R7
  assign link_tuning_word_c = word_c_a[UP_PORT]; // R2
  assign link_tuning_word_d = word_d_a[UP_PORT]; // R2

endmodule

/* stp_tuning_bank_monitor.sv */
// Checker on the top ports of the tuning bank.
// Assumes one core_clk domain and rst_b as its reset.
`timescale 1ns/10ps
module stp_tuning_bank_monitor
  import stp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [PORT_W-1:0] cfg_port,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic ld_req,
  input wire logic [1:0] ld_src,
  input wire logic [PORT_W-1:0] ld_port,
  input wire logic [7:0] ld_addr,
  input wire logic [31:0] ld_wdata,
  input wire logic up_link_down,
  input wire logic cfg_clear,
  input wire logic keep_cfg_on_link_down,
  input wire logic ordering_rule_disable,
  input wire logic [NUM_PORTS-1:0] port_disable,
  input wire logic [NUM_PORTS-1:0] rate_change_control,
  input wire logic [NUM_PORTS-1:0] first_generation_speed_limit,
  input wire logic [2*NUM_PORTS-1:0] rate_change_attempt_count,
  input wire logic [NUM_PORTS-1:0] phy_retrain_disable
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic ld_tl;
  logic ld_e;
  assign ld_tl = ld_req && ld_addr == OFS_TL && ld_port < 3'h6;
  assign ld_e = ld_req && ld_addr == OFS_WORD_E && ld_port < 3'h6;

  a_clear_on_down: assert property (
    $rose(up_link_down) && !keep_cfg_on_link_down |=> cfg_clear)
    else $error("cfg_clear missing after link down");
  a_clear_cause: assert property (
    cfg_clear |-> $past(up_link_down) && !$past(up_link_down, 2) &&
      !$past(keep_cfg_on_link_down))
    else $error("cfg_clear without cause");
  a_ld_disable: assert property (
    ld_tl |=> port_disable[$past(ld_port)] == $past(ld_wdata[10]))
    else $error("port_disable not loaded");
  a_ld_attempt: assert property (
    ld_tl |=> rate_change_attempt_count[2*$past(ld_port) +: 2] == $past(ld_wdata[9:8]))
    else $error("attempt count not loaded");
  a_ld_retrain: assert property (
    ld_tl |=> phy_retrain_disable[$past(ld_port)] == $past(ld_wdata[16]))
    else $error("retrain disable not loaded");
  a_ord_eeprom: assert property (
    ld_tl && ld_port == UP_PORT |=> ordering_rule_disable ==
    ($past(ld_src) == SRC_EEPROM ? $past(ld_wdata[6]) : $past(ordering_rule_disable)))
    else $error("ordering disable load source wrong");
  a_ld_gen1: assert property (
    ld_e |=> first_generation_speed_limit[$past(ld_port)] == $past(ld_wdata[31]))
    else $error("speed limit not loaded");
  a_ld_keep: assert property (
    ld_e && ld_port == UP_PORT |=> keep_cfg_on_link_down == $past(ld_wdata[11]))
    else $error("keep select not from upstream copy");
  a_keep_global: assert property (
    ld_e && ld_port != UP_PORT |=> $stable(keep_cfg_on_link_down))
    else $error("keep select changed by downstream copy");
  a_cfg_rate: assert property (
    cfg_req && cfg_we && cfg_addr == OFS_WORD_E && cfg_be[3] &&
    cfg_port < 3'h6 && !(ld_req && ld_port == cfg_port) |=>
    rate_change_control[$past(cfg_port)] == $past(cfg_wdata[30]))
    else $error("rate change control not written");
endmodule

bind stp_tuning_bank stp_tuning_bank_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b),
  .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_port(cfg_port), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .ld_req(ld_req), .ld_src(ld_src),
  .ld_port(ld_port), .ld_addr(ld_addr), .ld_wdata(ld_wdata), .up_link_down(up_link_down),
  .cfg_clear(cfg_clear), .keep_cfg_on_link_down(keep_cfg_on_link_down),
  .ordering_rule_disable(ordering_rule_disable), .port_disable(port_disable),
  .rate_change_control(rate_change_control),
  .first_generation_speed_limit(first_generation_speed_limit),
  .rate_change_attempt_count(rate_change_attempt_count),
  .phy_retrain_disable(phy_retrain_disable));

/* test_switch_port_tuning_regs.sv */
// Self-checking bench of the tuning bank with a loader model.
// Assumes stp_pkg constants; port 0 is upstream.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_switch_port_tuning_regs
  import stp_pkg::*;
;
  typedef struct packed {logic [2:0] port; logic [7:0] addr; logic [31:0] val;} stp_row_type;
  logic core_clk = 0, rst_b = 0, cfg_req = 0, cfg_we = 0, up_link_down = 0;
  logic [2:0] cfg_port = 0;
  logic [7:0] cfg_addr = 0;
  logic [3:0] cfg_be = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata, ld_wdata, wc, wd, r;
  logic cfg_ack, ld_req, ld_ack, cfg_clear, keep, ord;
  logic [1:0] ld_src;
  logic [2:0] ld_port;
  logic [7:0] ld_addr;
  logic [5:0] pd, rcc, fgs, prd;
  logic [11:0] rcac;
  int miscompares = 0, checks = 0;
  bit ok;
  stp_row_type rows [8] = '{'{3'h0, 8'h80, 32'h000F_0000}, '{3'h0, 8'h84, 32'h0000_0000},
    '{3'h0, 8'h88, 32'h7308_3333}, '{3'h3, 8'h88, 32'h3308_3333}, '{3'h5, 8'h8C, 32'h0079_1894},
    '{3'h0, 8'h8C, 32'h0079_1894}, '{3'h6, 8'h80, 32'h0000_0000}, '{3'h0, 8'h90, 32'h0000_0000}};

  always #5 core_clk = ~core_clk;

  stp_tuning_bank u_dut (.core_clk(core_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ld_req(ld_req), .ld_src(ld_src),
    .ld_port(ld_port), .ld_addr(ld_addr), .ld_wdata(ld_wdata), .ld_ack(ld_ack),
    .up_link_down(up_link_down), .cfg_clear(cfg_clear), .keep_cfg_on_link_down(keep),
    .ordering_rule_disable(ord), .port_disable(pd), .rate_change_control(rcc),
    .first_generation_speed_limit(fgs), .rate_change_attempt_count(rcac),
    .phy_retrain_disable(prd), .link_tuning_word_c(wc), .link_tuning_word_d(wd));
  stp_loader_model u_ld (.core_clk(core_clk), .ld_ack(ld_ack), .ld_req(ld_req),
    .ld_src(ld_src), .ld_port(ld_port), .ld_addr(ld_addr), .ld_wdata(ld_wdata));

  // ************************************************************
  // Bus tasks and verdict
  // ************************************************************
  task automatic cfg(input logic w, input logic [2:0] p, input logic [7:0] a,
      input logic [3:0] b, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    cfg_req = 1;
    cfg_we = w;
    cfg_port = p;
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    @(posedge core_clk);
    #1;
    cfg_req = 0;
    cfg_wdata = ~d;
    r = cfg_rdata;
    `CHK("cfg_ack", 1'b1, cfg_ack)
  endtask

  task automatic load(input logic [1:0] s, input logic [2:0] p, input logic [7:0] a,
      input logic [31:0] d);
    u_ld.load(s, p, a, d, ok);
    `CHK("ld_ack", 1'b1, ok)
  endtask

  task automatic link_down(input logic e);
    @(posedge core_clk);
    #1;
    up_link_down = 1;
    @(posedge core_clk);
    #1;
    `CHK("cfg_clear", e, cfg_clear)
    up_link_down = 0;
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    rst_b = 1;
    `CHK("rate_ctrl", 6'h01, rcc)
    `CHK("attempts", 12'h000, rcac)
    `CHK("port_dis", 6'h00, pd)
    `CHK("ord_dis", 1'b0, ord)
    `CHK("retrain_dis", 6'h3F, prd)
    `CHK("gen1", 6'h00, fgs)
    `CHK("keep", 1'b0, keep)
    `CHK("word_c up", 32'h000F_0000, wc)
    `CHK("word_d up", 32'h0000_0000, wd)
    foreach (rows[i])
    begin
      cfg(1'b0, rows[i].port, rows[i].addr, 4'h0, 32'h0);
      `CHK("reset read", rows[i].val, r)
    end
    cfg(1'b1, 3'h2, 8'h88, 4'h8, 32'hFFFF_FFFF);
    cfg(1'b0, 3'h2, 8'h88, 4'h0, 32'h0);
    `CHK("word_e p2", 32'hF308_3333, r)
    `CHK("rate p2", 1'b1, rcc[2])
    load(SRC_I2C, 3'h0, 8'h80, 32'hA5A5_0F0F);
    `CHK("word_c load", 32'hA5A5_0F0F, wc)
    cfg(1'b1, 3'h1, 8'h80, 4'hF, 32'h0000_0000);
    `CHK("word_c up only", 32'hA5A5_0F0F, wc)
    load(SRC_EEPROM, 3'h0, 8'h84, 32'h1234_5678);
    `CHK("word_d load", 32'h1234_5678, wd)
    cfg(1'b1, 3'h0, 8'h84, 4'hF, 32'h0000_0000);
    cfg(1'b0, 3'h5, 8'h84, 4'h0, 32'h0000_0000);
    `CHK("word_d view", 32'h1234_5678, r)
    link_down(1'b1);
    load(SRC_SMBUS, 3'h0, 8'h88, 32'h7308_3B33);
    cfg(1'b0, 3'h3, 8'h88, 4'h0, 32'h0);
    `CHK("word_e p3 global", 32'h3308_3B33, r)
    `CHK("keep", 1'b1, keep)
    load(SRC_SMBUS, 3'h3, 8'h88, 32'hC000_0000);
    cfg(1'b0, 3'h3, 8'h88, 4'h0, 32'h0000_0000);
    `CHK("word_e p3 mixed", 32'hF308_3B33, r)
    `CHK("keep p3 load", 1'b1, keep)
    `CHK("gen1 p3", 1'b1, fgs[3])
    `CHK("rate p3", 1'b1, rcc[3])
    link_down(1'b0);
    load(SRC_I2C, 3'h4, 8'h8C, 32'h0078_1FD4);
    `CHK("port_dis p4", 1'b1, pd[4])
    `CHK("attempts p4", 2'h3, rcac[9:8])
    `CHK("retrain p4", 1'b0, prd[4])
    load(SRC_I2C, 3'h0, 8'h8C, 32'h0079_18D4);
    `CHK("ord_dis i2c", 1'b0, ord)
    load(SRC_EEPROM, 3'h0, 8'h8C, 32'h0079_18D4);
    `CHK("ord_dis eeprom", 1'b1, ord)
    @(posedge core_clk);
    #1;
    rst_b = 0;
    @(posedge core_clk);
    #1;
    rst_b = 1;
    `CHK("ord after reset", 1'b0, ord)
    `CHK("port_dis after reset", 6'h00, pd)
    `CHK("keep after reset", 1'b0, keep)
    `CHK("word_d after reset", 32'h0000_0000, wd)
    `CHK("gen1 after reset", 6'h00, fgs)
    cfg(1'b0, 3'h0, 8'h88, 4'h0, 32'h0000_0000);
    `CHK("word_e after reset", 32'h7308_3333, r)
    final_report();
  end
endmodule
